/* phy_status_summary_upper.sv */
// apb slave for the phy status summary word and its companions
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module phy_status_summary_upper
    import phy_status_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_error_event,
    input wire logic false_carrier_event,
    input wire logic polarity_inverted,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic page_received_event,
    input wire logic interrupt_event,
    input wire logic remote_fault_event,
    input wire logic crossover_auto_state,
    output logic crossover_swapped
);

    // ****************************************************
    // state
    // ****************************************************

    typedef struct packed {
        bus_state_type st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic auto_en;
        logic force_x;
        logic swapped;
        logic [CNT_W-1:0] rxerr_cnt;
        logic [CNT_W-1:0] fcar_cnt;
    } top_state_type;

    top_state_type state_q;
    top_state_type state_d;

    // ****************************************************
    // helper functions
    // ****************************************************

    // counters stick at full scale rather than wrap to zero,
    // so software never mistakes a flood for silence
    function automatic logic [CNT_W-1:0] count_step(
        input logic [CNT_W-1:0] cnt,
        input logic ev,
        input logic clr
    );
        logic [CNT_W-1:0] base;
        base = clr ? '0 : cnt;
        if (ev && (base != {CNT_W{1'b1}})) begin
            return base + 1'b1;
        end
        return base;
    endfunction

    // widen a counter to a register word
    function automatic logic [REG_W-1:0] widen(
        input logic [CNT_W-1:0] cnt
    );
        logic [REG_W-1:0] w;
        w = '0;
        w[CNT_W-1:0] = cnt;
        return w;
    endfunction

    // true for every index that holds a register
    function automatic logic is_mapped(input logic [4:0] idx);
        logic hit;
        hit = 1'b0;
        unique case (idx)
            IDX_BASIC_STAT, IDX_AN_EXP, IDX_SUMMARY, IDX_INT_STAT,
            IDX_FCAR_CNT, IDX_RXERR_CNT, IDX_TENBASE, IDX_CTRL: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // true when the decoded access hits one register index
    // the mapped check guards every strobe: a refused access clears nothing
    function automatic logic hits(input logic [4:0] idx,
                                  input logic [4:0] want,
                                  input logic ok);
        return ok && (idx == want);
    endfunction

    // ****************************************************
    // latch bank
    // ****************************************************

    // the latches keep their own state so this module only decodes
    status_link_if lnk ();

    status_latches u_latches (
        .pclk(pclk),
        .presetn(presetn),
        .rx_error_event(rx_error_event),
        .false_carrier_event(false_carrier_event),
        .polarity_inverted(polarity_inverted),
        .signal_detect(signal_detect),
        .descrambler_lock(descrambler_lock),
        .page_received_event(page_received_event),
        .interrupt_event(interrupt_event),
        .remote_fault_event(remote_fault_event),
        .lnk(lnk)
    );

    // ****************************************************
    // address decode
    // ****************************************************

    // word indices only: byte lanes are not supported, so any access
    // whose two low address bits are not zero is refused with pslverr
    logic [4:0] idx;
    logic aligned;
    logic addr_ok;
    logic rd_take;
    logic wr_done;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign addr_ok = aligned && is_mapped(idx);

    // a read is served on the first access edge; clears fire there
    // too, so the bits cleared are exactly the bits returned
    assign rd_take = (state_q.st == ST_IDLE) && psel && penable
                     && !pwrite;

    // a write lands only on the completing edge
    // writes to read-only words fall through the decode and are dropped
    assign wr_done = (state_q.st == ST_RESP) && psel && penable
                     && pwrite && state_q.pready;

    // ****************************************************
    // clear-on-read strobes
    // ****************************************************

    // an event in the clearing cycle wins over the clear, so a bit
    // set while software reads is shown on the next read, never lost
    // summary read refreshes latched low bits
    assign lnk.clr_summary = rd_take && hits(idx, IDX_SUMMARY, addr_ok);
    // counter read clears receive error latch
    assign lnk.clr_rxerr_cnt = rd_take && hits(idx, IDX_RXERR_CNT, addr_ok);
    // counter read clears false carrier latch
    assign lnk.clr_fcar_cnt = rd_take && hits(idx, IDX_FCAR_CNT, addr_ok);
    // only its own register clears polarity
    assign lnk.clr_tenbase = rd_take && hits(idx, IDX_TENBASE, addr_ok);
    assign lnk.clr_an_exp = rd_take && hits(idx, IDX_AN_EXP, addr_ok);
    assign lnk.clr_int_stat = rd_take && hits(idx, IDX_INT_STAT, addr_ok);
    // basic status read clears remote fault
    assign lnk.clr_basic_stat = rd_take && hits(idx, IDX_BASIC_STAT, addr_ok);

    // ****************************************************
    // register words
    // ****************************************************

    logic [REG_W-1:0] summary_word;
    logic [REG_W-1:0] read_word;

    // assemble the summary word from live and latched state
    always_comb begin
        summary_word = RST_WORD;
        summary_word[BIT_RSVD] = 1'b0;
        summary_word[BIT_XOVER] = state_q.swapped;
        summary_word[BIT_RXERR] = lnk.rxerr_latch;
        summary_word[BIT_POL] = lnk.polarity;
        summary_word[BIT_FCAR] = lnk.fcar_latch;
        summary_word[BIT_SIGDET] = lnk.sig_detect;
        summary_word[BIT_LOCK] = lnk.lock;
        summary_word[BIT_PAGE] = lnk.page_rx;
        summary_word[BIT_INT] = lnk.int_pend;
        summary_word[BIT_RFAULT] = lnk.remote_fault;
    end

    // companion words show only the bits this block owns; the rest
    // read zero, which keeps the decode small
    // read multiplexer; unmapped indices read zero
    always_comb begin
        read_word = RST_WORD;
        unique case (idx)
            IDX_SUMMARY: begin
                read_word = summary_word;
            end
            IDX_RXERR_CNT: begin
                read_word = widen(state_q.rxerr_cnt);
            end
            IDX_FCAR_CNT: begin
                read_word = widen(state_q.fcar_cnt);
            end
            IDX_TENBASE: begin
                read_word[BIT_TB_POL] = lnk.polarity;
            end
            IDX_AN_EXP: begin
                read_word[BIT_EXP_PAGE] = lnk.page_rx;
            end
            IDX_INT_STAT: begin
                read_word[BIT_INT_PEND] = lnk.int_pend;
            end
            IDX_BASIC_STAT: begin
                read_word[BIT_BASIC_RFAULT] = lnk.remote_fault;
            end
            IDX_CTRL: begin
                read_word[BIT_CTRL_AUTO] = state_q.auto_en;
                read_word[BIT_CTRL_FORCE] = state_q.force_x;
            end
            default: begin
                read_word = RST_WORD;
            end
        endcase
        if (!addr_ok) begin
            read_word = RST_WORD;
        end
    end

    // ****************************************************
    // next state
    // ****************************************************

    always_comb begin
        state_d = state_q;

        // bus slave: answer one cycle into the access phase
        unique case (state_q.st)
            ST_IDLE: begin
                state_d.pready = 1'b0;
                if (psel && penable) begin
                    state_d.st = ST_RESP;
                    state_d.pready = 1'b1;
                    state_d.pslverr = !addr_ok;
                    state_d.prdata = pwrite ? 32'h0000_0000
                                            : {16'h0000, read_word};
                end
            end
            ST_RESP: begin
                state_d.st = ST_IDLE;
                state_d.pready = 1'b0;
                state_d.pslverr = 1'b0;
            end
            default: begin
                // an illegal code drops the slave back to idle
                state_d.st = ST_IDLE;
                state_d.pready = 1'b0;
                state_d.pslverr = 1'b0;
            end
        endcase

        // control register write; summary writes dropped
        if (wr_done && hits(idx, IDX_CTRL, addr_ok)) begin
            state_d.auto_en = pwdata[BIT_CTRL_AUTO];
            state_d.force_x = pwdata[BIT_CTRL_FORCE];
        end

        // the swap follows its controls one edge late, so a change of
        // force or enable never glitches the pair select
        // force wins, auto tracks the live algorithm
        if (state_q.force_x) begin
            state_d.swapped = 1'b1;
        end else if (state_q.auto_en) begin
            state_d.swapped = crossover_auto_state;
        end else begin
            state_d.swapped = 1'b0;
        end

        // error counter behind the receive error latch
        state_d.rxerr_cnt = count_step(state_q.rxerr_cnt,
                                       rx_error_event, lnk.clr_rxerr_cnt);
        // counter behind the false carrier latch
        state_d.fcar_cnt = count_step(state_q.fcar_cnt,
                                      false_carrier_event,
                                      lnk.clr_fcar_cnt);
    end

    // ****************************************************
    // registers
    // ****************************************************

    // everything but the bus state returns to zero; bus idles in its first state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.st <= ST_IDLE;
            state_q.pready <= RST_BIT;
            state_q.pslverr <= RST_BIT;
            state_q.prdata <= 32'h0000_0000;
            state_q.auto_en <= RST_BIT;
            state_q.force_x <= RST_BIT;
            state_q.swapped <= RST_BIT;
            state_q.rxerr_cnt <= '0;
            state_q.fcar_cnt <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************
    // outputs, each straight from a flip-flop
    // ****************************************************

    // prdata is meaningful only in the cycle in which pready is high
    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    // drives the pair swap from the same bit software sees
    assign crossover_swapped = state_q.swapped;

endmodule

`default_nettype wire

/* phy_status_pkg.sv */
// constants and types shared by the phy status summary block
package phy_status_pkg;

    // register word width and bus address width
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 7;

    // register indices; the byte address is four times the index
    localparam logic [4:0] IDX_BASIC_STAT = 5'h01;
    localparam logic [4:0] IDX_AN_EXP = 5'h06;
    localparam logic [4:0] IDX_SUMMARY = 5'h10;
    localparam logic [4:0] IDX_INT_STAT = 5'h12;
    localparam logic [4:0] IDX_FCAR_CNT = 5'h14;
    localparam logic [4:0] IDX_RXERR_CNT = 5'h15;
    localparam logic [4:0] IDX_TENBASE = 5'h1b;
    localparam logic [4:0] IDX_CTRL = 5'h1c;

    // summary word bit positions
    localparam int unsigned BIT_RSVD = 15;
    localparam int unsigned BIT_XOVER = 14;
    localparam int unsigned BIT_RXERR = 13;
    localparam int unsigned BIT_POL = 12;
    localparam int unsigned BIT_FCAR = 11;
    localparam int unsigned BIT_SIGDET = 10;
    localparam int unsigned BIT_LOCK = 9;
    localparam int unsigned BIT_PAGE = 8;
    localparam int unsigned BIT_INT = 7;
    localparam int unsigned BIT_RFAULT = 6;

    // bit positions in the companion registers
    localparam int unsigned BIT_TB_POL = 4;
    localparam int unsigned BIT_EXP_PAGE = 1;
    localparam int unsigned BIT_BASIC_RFAULT = 4;
    localparam int unsigned BIT_INT_PEND = 15;
    localparam int unsigned BIT_CTRL_AUTO = 15;
    localparam int unsigned BIT_CTRL_FORCE = 14;

    // reset values
    localparam logic RST_BIT = 1'b0;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } bus_state_type;

endpackage

/* status_link_if.sv */
// clear strobes and latched status between bus slave and latch bank
`timescale 1ns/1ps
`default_nettype none

interface status_link_if;
    logic clr_summary;
    logic clr_rxerr_cnt;
    logic clr_fcar_cnt;
    logic clr_tenbase;
    logic clr_an_exp;
    logic clr_int_stat;
    logic clr_basic_stat;
    logic rxerr_latch;
    logic fcar_latch;
    logic polarity;
    logic sig_detect;
    logic lock;
    logic page_rx;
    logic int_pend;
    logic remote_fault;

    modport ctrl (
        output clr_summary, clr_rxerr_cnt, clr_fcar_cnt, clr_tenbase,
        output clr_an_exp, clr_int_stat, clr_basic_stat,
        input rxerr_latch, fcar_latch, polarity, sig_detect,
        input lock, page_rx, int_pend, remote_fault
    );

    modport latch (
        input clr_summary, clr_rxerr_cnt, clr_fcar_cnt, clr_tenbase,
        input clr_an_exp, clr_int_stat, clr_basic_stat,
        output rxerr_latch, fcar_latch, polarity, sig_detect,
        output lock, page_rx, int_pend, remote_fault
    );
endinterface

`default_nettype wire

/* status_latches.sv */
// latching status bits that feed the summary word
`timescale 1ns/1ps
`default_nettype none

module status_latches
    import phy_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rx_error_event,
    input wire logic false_carrier_event,
    input wire logic polarity_inverted,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic page_received_event,
    input wire logic interrupt_event,
    input wire logic remote_fault_event,
    status_link_if.latch lnk
);

    typedef struct packed {
        logic rxerr;
        logic fcar;
        logic pol;
        logic sigdet;
        logic lock;
        logic page;
        logic int_pend;
        logic rfault;
    } latch_state_type;

    latch_state_type state_q;
    latch_state_type state_d;

    // latch high: a new event beats a clear in the same cycle
    function automatic logic hold_high(input logic q, input logic ev,
                                       input logic clr);
        return ev | (q & ~clr);
    endfunction

    // latch low: a drop sticks until the summary read refreshes it
    function automatic logic hold_low(input logic q, input logic live,
                                      input logic refresh);
        return refresh ? live : (q & live);
    endfunction

    // next state of every latch
    always_comb begin
        state_d = state_q;
        state_d.rxerr = hold_high(state_q.rxerr, rx_error_event,
                                  lnk.clr_rxerr_cnt);
        state_d.fcar = hold_high(state_q.fcar, false_carrier_event,
                                 lnk.clr_fcar_cnt);
        // polarity, cleared by its own register
        state_d.pol = hold_high(state_q.pol, polarity_inverted,
                                lnk.clr_tenbase);
        state_d.sigdet = hold_low(state_q.sigdet, signal_detect,
                                  lnk.clr_summary);
        state_d.lock = hold_low(state_q.lock, descrambler_lock,
                                lnk.clr_summary);
        state_d.page = hold_high(state_q.page, page_received_event,
                                 lnk.clr_an_exp);
        state_d.int_pend = hold_high(state_q.int_pend, interrupt_event,
                                     lnk.clr_int_stat);
        state_d.rfault = hold_high(state_q.rfault, remote_fault_event,
                                   lnk.clr_basic_stat);
    end

    // every latch comes out of reset at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= {8{RST_BIT}};
        end else begin
            state_q <= state_d;
        end
    end

    assign lnk.rxerr_latch = state_q.rxerr;
    assign lnk.fcar_latch = state_q.fcar;
    assign lnk.polarity = state_q.pol;
    assign lnk.sig_detect = state_q.sigdet;
    assign lnk.lock = state_q.lock;
    assign lnk.page_rx = state_q.page;
    assign lnk.int_pend = state_q.int_pend;
    assign lnk.remote_fault = state_q.rfault;

endmodule

`default_nettype wire

/* phy_status_summary_upper_assertions.sv */
// port-level checks for the phy status summary block
`timescale 1ns/1ps
`default_nettype none

module phy_status_summary_upper_assertions
    import phy_status_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_error_event,
    input wire logic false_carrier_event,
    input wire logic polarity_inverted,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic page_received_event,
    input wire logic interrupt_event,
    input wire logic remote_fault_event,
    input wire logic crossover_auto_state,
    input wire logic crossover_swapped
);
    // ****
    // helpers
    // ****
    // completing read of the summary word; its data was taken one edge back
    wire logic rd_sum;
    assign rd_sum = pready && psel && !pwrite && paddr == {IDX_SUMMARY, 2'b00};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answer: one wait state, one-cycle pulse, errors on misalignment
    chk_ready_after: assert property (
        psel && penable && !$past(penable) |=> pready)
        else $error("pready not one cycle after access start");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_bad_addr: assert property (psel && pready && paddr[1:0] != 2'b00
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("misaligned access not refused");
    chk_top_zero: assert property (rd_sum |-> prdata[31:15] == '0)
        else $error("summary top bits not zero");
    chk_xover_match: assert property (
        rd_sum |-> prdata[14] == $past(crossover_swapped))
        else $error("crossover bit differs from crossover output");
    chk_rxerr_set: assert property (
        rd_sum && $past(rx_error_event, 2) |-> prdata[13])
        else $error("receive error not latched");
    chk_sigdet_low: assert property (
        rd_sum && !$past(signal_detect, 2) |-> !prdata[10])
        else $error("signal detect low not held");
    chk_lock_low: assert property (
        rd_sum && !$past(descrambler_lock, 2) |-> !prdata[9])
        else $error("lock low not held");
    chk_page_set: assert property (
        rd_sum && $past(page_received_event, 2) |-> prdata[8])
        else $error("page received not reported");
endmodule

`default_nettype wire

/* mgmt_host_model.sv */
// apb host model issuing register transfers to the summary block
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model
    import phy_status_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    bit hung = 1'b0;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // ****
    // one transfer, entered just after a rising edge
    // ****
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // bounded wait: the latency is the slave's to choose
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hung = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so a stale value never passes
        paddr <= ~a;
        pwdata <= ~wd;
        @(posedge pclk);
    endtask
endmodule

`default_nettype wire

/* phy_status_summary_upper_tb_top.sv */
// self-checking bench for the phy status summary block
`timescale 1ns/1ps
`default_nettype none

module phy_status_summary_upper_tb_top import phy_status_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xauto, xsw;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    // rx err, false carrier, polarity, sig detect, lock, page, int, fault
    logic [7:0] ev;
    int num_errors = 0;
    int n_compared = 0;

    phy_status_summary_upper #(.CNT_W(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_error_event(ev[0]),
        .false_carrier_event(ev[1]), .polarity_inverted(ev[2]),
        .signal_detect(ev[3]), .descrambler_lock(ev[4]),
        .page_received_event(ev[5]), .interrupt_event(ev[6]),
        .remote_fault_event(ev[7]), .crossover_auto_state(xauto),
        .crossover_swapped(xsw));
    mgmt_host_model host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [6:0] a,
                       input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        host.xfer(w, a, wd, d, e);
        if (host.hung) begin
            num_errors++;
            print_verdict;
        end
    endtask
    task automatic rd(input logic [4:0] idx, output logic [31:0] d);
        logic e;
        bus(1'b0, {idx, 2'b00}, 32'h0000_0000, d, e);
        chk(e, 1'b0);
    endtask
    // read the summary with input k inverted for just the setup edge
    task automatic rd_ev(input int k, output logic [31:0] d);
        ev[k] <= ~ev[k];
        fork
            rd(IDX_SUMMARY, d);
            begin
                @(posedge pclk);
                ev[k] <= ~ev[k];
            end
        join
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset;
        logic [31:0] d;
        logic e;
        chk(xsw, 1'b0);
        rd(IDX_SUMMARY, d);
        chk(d, 32'h0000_0000);
        bus(1'b1, {IDX_SUMMARY, 2'b00}, 32'hFFFF_FFFF, d, e);
        chk(e, 32'h0000_0000);
        rd(IDX_SUMMARY, d);
        chk(d, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_xover;
        logic [31:0] d;
        logic e;
        for (int i = 0; i < 8; i++) begin
            xauto <= i[0];
            bus(1'b1, {IDX_CTRL, 2'b00}, {16'h0000, i[2:1], 14'h0000}, d, e);
            repeat (2) @(posedge pclk);
            chk(xsw, i[1] | (i[2] & i[0]));
            rd(IDX_SUMMARY, d);
            chk(d[14], i[1] | (i[2] & i[0]));
            rd(IDX_CTRL, d);
            chk(d[15:14], i[2:1]);
        end
        $display("crossover test done");
    endtask
    // set by one event, survives summary reads, cleared by its own read
    task automatic t_latch(input int k, input int sb, input logic [4:0] idx,
                           input int cb);
        logic [31:0] d;
        rd_ev(k, d);
        chk(d[sb], 1'b1);
        rd(IDX_SUMMARY, d);
        chk(d[sb], 1'b1);
        rd(idx, d);
        chk(d[cb], 1'b1);
        rd(IDX_SUMMARY, d);
        chk(d[sb], 1'b0);
        $display("latch test %0d done", k);
    endtask
    task automatic t_low;
        logic [31:0] d;
        ev[4:3] <= 2'b11;
        rd(IDX_SUMMARY, d);
        rd(IDX_SUMMARY, d);
        chk(d[10:9], 2'b11);
        rd_ev(3, d);
        chk(d[10:9], 2'b01);
        rd(IDX_SUMMARY, d);
        chk(d[10:9], 2'b11);
        rd_ev(4, d);
        chk(d[10:9], 2'b10);
        $display("latching low test done");
    endtask
    task automatic t_refuse;
        logic [31:0] d;
        logic e;
        bus(1'b0, 7'h08, 32'h0000_0000, d, e);
        chk(e, 32'h0000_0001);
        chk(d, 32'h0000_0000);
        bus(1'b0, 7'h41, 32'h0000_0000, d, e);
        chk(e, 32'h0000_0001);
        chk(d, 32'h0000_0000);
        $display("refusal test done");
    endtask

    // clock, 25 MHz
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        ev = 8'h00;
        xauto = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_xover;
        t_latch(0, BIT_RXERR, IDX_RXERR_CNT, 0);
        t_latch(1, BIT_FCAR, IDX_FCAR_CNT, 0);
        t_latch(2, BIT_POL, IDX_TENBASE, BIT_TB_POL);
        t_latch(5, BIT_PAGE, IDX_AN_EXP, BIT_EXP_PAGE);
        t_latch(6, BIT_INT, IDX_INT_STAT, BIT_INT_PEND);
        t_latch(7, BIT_RFAULT, IDX_BASIC_STAT, BIT_BASIC_RFAULT);
        t_low;
        t_refuse;
        print_verdict;
    end
endmodule

bind phy_status_summary_upper phy_status_summary_upper_assertions #(
    .CNT_W(CNT_W)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_error_event(rx_error_event),
    .false_carrier_event(false_carrier_event),
    .polarity_inverted(polarity_inverted), .signal_detect(signal_detect),
    .descrambler_lock(descrambler_lock),
    .page_received_event(page_received_event),
    .interrupt_event(interrupt_event),
    .remote_fault_event(remote_fault_event),
    .crossover_auto_state(crossover_auto_state),
    .crossover_swapped(crossover_swapped));

`default_nettype wire
